// file: hdl/bcdrtc_top.sv
// bcdrtc_top: bcd calendar clock with four-word exchange field behind an ahb-lite slave.
// assumes a single ahb master, one 10 MHz clock; por_i is the cold (battery loss) reset.
// Function
// - reads give 10 ms resolution; sets take whole seconds only.
// - date advance uses true month lengths, February 29 in leap years.
// - set checks day, month, year form a real date including leap years.
// - hour word bit 15 selects 24-hour; bit 14 is am/pm, zero in 24-hour.
// - am covers midnight to noon, pm covers noon to midnight.
// - every exchanged time and date field is bcd coded.
// - fields stay in their documented ranges, weekday Monday 0 to Sunday 6.
// - exchange field is four consecutive 16-bit words, for set and read.
// - set layout: seconds, format/hours/minutes, day/weekday, year/month.
// - read layout equals set layout with hundredths in word 1 low byte.
// - once set, time survives supply loss and warm restart.
// - set copies field into clock; read copies clock into field.
// - flag byte view: word n high byte x+n-1, low byte x+4+n-1.
// - set with nonzero hundredths byte is rejected.
// - set with nonzero word 3 bits 3 to 0 is rejected.
// - rejected set flags error and keeps running time unchanged.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bcdrtc_top #(
  parameter int unsigned TICK_CYCLES = bcdrtc_pkg::TICK_CYCLES
) (
  // clock and resets
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        por_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // interrupt
  output logic             irq_o
);
  generate
    if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00ffffff) begin : g_bad_tick
      $error("bcdrtc_top: TICK_CYCLES out of range");
    end
  endgenerate

  // bus state
  logic        wr_pend,   next_wr_pend;
  logic [7:0]  wr_addr,   next_wr_addr;
  logic [31:0] rdata,     next_rdata;
  logic        ready,     next_ready;
  // exchange field and control
  logic [15:0] fld [4];
  logic [15:0] next_fld [4];
  logic        cmd_set,   next_cmd_set;
  logic        cmd_rd,    next_cmd_rd;
  logic [7:0]  err_code,  next_err_code;
  logic [bcdrtc_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [bcdrtc_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
  logic        irq,       next_irq;
  // running clock, kept through warm restart
  bcdrtc_pkg::bcdrtc_time_t tm, next_tm;
  logic        set_once,  next_set_once;
  logic        fmt24,     next_fmt24;
  logic [23:0] tick_cnt,  next_tick_cnt;

  bcdrtc_pkg::bcdrtc_time_t chk_tm, adv_tm;
  logic        chk_fmt24;
  logic [7:0]  chk_err;
  logic        addr_ok;
  logic        tick;
  logic        wr_now;
  logic [31:0] rd_mux;
  logic [15:0] rd_word [4];
  logic [4:0]  h12;
  logic [7:0]  hour_bcd;
  logic [7:0]  h12_bcd;
  localparam int unsigned IRQ_W_L = bcdrtc_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] ev;

  bcdrtc_chk u_chk (
    .w0_i    (fld[0]),
    .w1_i    (fld[1]),
    .w2_i    (fld[2]),
    .w3_i    (fld[3]),
    .tm_o    (chk_tm),
    .fmt24_o (chk_fmt24),
    .err_o   (chk_err)
  );

  bcdrtc_adv u_adv (
    .cur_i (tm),
    .nxt_o (adv_tm)
  );

  // read image of the running clock in the set layout plus hundredths
  always_comb begin
    h12 = (tm.hour == 5'h00) ? 5'h0c : (tm.hour > 5'h0c) ? 5'(tm.hour - 5'h0c) : tm.hour;
    hour_bcd   = bcdrtc_pkg::bin2bcd({2'h0, tm.hour});
    h12_bcd    = bcdrtc_pkg::bin2bcd({2'h0, h12});
    rd_word[0] = {bcdrtc_pkg::bin2bcd({1'h0, tm.sec}), bcdrtc_pkg::bin2bcd(tm.hund)};
    if (fmt24) begin
      rd_word[1] = {2'h2, hour_bcd[5:0],
                    bcdrtc_pkg::bin2bcd({1'h0, tm.min})};
    end else begin
      rd_word[1] = {1'h0, (tm.hour >= 5'h0c), h12_bcd[5:0],
                    bcdrtc_pkg::bin2bcd({1'h0, tm.min})};
    end
    rd_word[2] = {bcdrtc_pkg::bin2bcd({2'h0, tm.day}), 1'h0, tm.wday, 4'h0};
    rd_word[3] = {bcdrtc_pkg::bin2bcd(tm.year), bcdrtc_pkg::bin2bcd({3'h0, tm.mon})};
  end

  // ahb address decode, register read mux
  always_comb begin
    addr_ok = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0) &&
              (haddr_i[7:0] <= bcdrtc_pkg::OFF_FLAGB7);
    rd_mux  = 32'h00000000;
    if (haddr_i[7:0] <= bcdrtc_pkg::OFF_FIELD3) begin
      rd_mux = {16'h0000, fld[haddr_i[3:2]]};
    end else if (haddr_i[7:0] >= bcdrtc_pkg::OFF_FLAGB0) begin
      // byte k: words 0..3 high bytes, then words 0..3 low bytes
      rd_mux = haddr_i[4] ? {24'h000000, fld[haddr_i[3:2]][7:0]}
                          : {24'h000000, fld[haddr_i[3:2]][15:8]};
    end else if (haddr_i[7:0] == bcdrtc_pkg::OFF_STATE) begin
      rd_mux[bcdrtc_pkg::ST_SET_BIT]                   = set_once;
      rd_mux[bcdrtc_pkg::ST_FMT24_BIT]                 = fmt24;
      rd_mux[bcdrtc_pkg::ST_ERR_LSB +: 8]              = err_code;
    end else if (haddr_i[7:0] == bcdrtc_pkg::OFF_IRQ_STAT) begin
      rd_mux[IRQ_W_L-1:0] = irq_stat;
    end else if (haddr_i[7:0] == bcdrtc_pkg::OFF_IRQ_MASK) begin
      rd_mux[IRQ_W_L-1:0] = irq_mask;
    end
  end

  // bus pipeline: zero wait states, data registered at the address phase
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_rdata   = rdata;
    next_ready   = 1'b1;
    if (hsel_i && htrans_i[1] && hready_i) begin
      next_wr_pend = hwrite_i && addr_ok;
      next_wr_addr = haddr_i[7:0];
      next_rdata   = (!hwrite_i && addr_ok) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata   <= 32'h00000000;
      ready   <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rdata   <= next_rdata;
      ready   <= next_ready;
    end
  end

  // field, commands, status and interrupt
  always_comb begin
    wr_now        = wr_pend;
    next_fld      = fld;
    next_cmd_set  = 1'b0;
    next_cmd_rd   = 1'b0;
    next_err_code = err_code;
    next_irq_mask = irq_mask;
    ev            = '0;
    if (cmd_set) begin
      next_err_code = chk_err;
      ev[bcdrtc_pkg::IRQ_DONE_BIT] = (chk_err == bcdrtc_pkg::ERR_NONE);
      ev[bcdrtc_pkg::IRQ_ERR_BIT]  = (chk_err != bcdrtc_pkg::ERR_NONE);
    end else if (cmd_rd) begin
      next_fld = rd_word;
      ev[bcdrtc_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    ev[bcdrtc_pkg::IRQ_SEC_BIT] = tick && set_once && (tm.hund == bcdrtc_pkg::MAX_HUND);
    next_irq_stat = irq_stat | ev;
    // a later bus write to the field wins over a read snapshot taken in the same cycle
    if (wr_now) begin
      if (wr_addr <= bcdrtc_pkg::OFF_FIELD3) begin
        next_fld[wr_addr[3:2]] = hwdata_i[15:0];
      end else if (wr_addr >= bcdrtc_pkg::OFF_FLAGB0) begin
        if (wr_addr[4]) begin
          next_fld[wr_addr[3:2]][7:0]  = hwdata_i[7:0];
        end else begin
          next_fld[wr_addr[3:2]][15:8] = hwdata_i[7:0];
        end
      end else if (wr_addr == bcdrtc_pkg::OFF_CMD) begin
        next_cmd_set = hwdata_i[bcdrtc_pkg::CMD_SET_BIT];
        next_cmd_rd  = hwdata_i[bcdrtc_pkg::CMD_READ_BIT];
      end else if (wr_addr == bcdrtc_pkg::OFF_IRQ_STAT) begin
        // write one to clear; a same-cycle event stays set
        next_irq_stat = (irq_stat & ~hwdata_i[IRQ_W_L-1:0]) | ev;
      end else if (wr_addr == bcdrtc_pkg::OFF_IRQ_MASK) begin
        next_irq_mask = hwdata_i[IRQ_W_L-1:0];
      end
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fld      <= '{default: 16'h0000};
      cmd_set  <= 1'b0;
      cmd_rd   <= 1'b0;
      err_code <= bcdrtc_pkg::ERR_NONE;
      irq_stat <= '0;
      irq_mask <= bcdrtc_pkg::IRQ_MASK_RST;
      irq      <= 1'b0;
    end else begin
      fld      <= next_fld;
      cmd_set  <= next_cmd_set;
      cmd_rd   <= next_cmd_rd && !next_cmd_set;
      err_code <= next_err_code;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq      <= next_irq;
    end
  end

  // running clock; only the cold reset clears it, a warm restart leaves it running
  always_comb begin
    tick          = (tick_cnt == 24'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 24'h000000 : 24'(tick_cnt + 24'h000001);
    next_tm       = tm;
    next_set_once = set_once;
    next_fmt24    = fmt24;
    if (cmd_set && chk_err == bcdrtc_pkg::ERR_NONE) begin
      next_tm       = chk_tm;
      next_fmt24    = chk_fmt24;
      next_set_once = 1'b1;
      // restart the 10 ms phase so the set second starts whole
      next_tick_cnt = 24'h000000;
    end else if (tick && set_once) begin
      next_tm = adv_tm;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_i) begin
      tm       <= bcdrtc_pkg::TIME_RST;
      set_once <= 1'b0;
      fmt24    <= 1'b1;
      tick_cnt <= 24'h000000;
    end else begin
      tm       <= next_tm;
      set_once <= next_set_once;
      fmt24    <= next_fmt24;
      tick_cnt <= next_tick_cnt;
    end
  end

  assign hrdata_o    = rdata;
  assign hreadyout_o = ready;
  assign hresp_o     = 1'b0;
  assign irq_o       = irq;
endmodule // bcdrtc_top

// file: hdl/bcdrtc_pkg.sv
// bcdrtc_pkg: constants, register map, time type and bcd helpers of the bcd calendar clock.
// assumes one 10 MHz clock; every user includes nothing and writes bcdrtc_pkg::name.
package bcdrtc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_PERIOD_MS = 10;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFF_FIELD0    = 8'h00;
  localparam logic [7:0] OFF_FIELD3    = 8'h0c;
  localparam logic [7:0] OFF_CMD       = 8'h10;
  localparam logic [7:0] OFF_STATE     = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] OFF_FLAGB0    = 8'h20;
  localparam logic [7:0] OFF_FLAGB7    = 8'h3c;

  // command and state bits
  localparam int unsigned CMD_SET_BIT   = 0;
  localparam int unsigned CMD_READ_BIT  = 1;
  localparam int unsigned ST_SET_BIT    = 0;
  localparam int unsigned ST_FMT24_BIT  = 1;
  localparam int unsigned ST_ERR_LSB    = 8;

  // interrupt status bits
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_DONE_BIT  = 0;
  localparam int unsigned IRQ_ERR_BIT   = 1;
  localparam int unsigned IRQ_SEC_BIT   = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // field word bit positions
  localparam int unsigned FMT24_BIT = 15;
  localparam int unsigned PM_BIT    = 14;

  // set error codes, zero means accepted
  localparam logic [7:0] ERR_NONE  = 8'h00;
  localparam logic [7:0] ERR_YEAR  = 8'h01;
  localparam logic [7:0] ERR_MONTH = 8'h02;
  localparam logic [7:0] ERR_DAY   = 8'h03;
  localparam logic [7:0] ERR_WDAY  = 8'h04;
  localparam logic [7:0] ERR_HOUR  = 8'h05;
  localparam logic [7:0] ERR_MIN   = 8'h06;
  localparam logic [7:0] ERR_SEC   = 8'h07;
  localparam logic [7:0] ERR_HUND  = 8'h08;
  localparam logic [7:0] ERR_LOWB  = 8'h09;

  // field ranges, binary
  localparam logic [6:0] MAX_HUND = 7'h63;
  localparam logic [5:0] MAX_MS   = 6'h3b;
  localparam logic [4:0] MAX_HOUR = 5'h17;
  localparam logic [2:0] MAX_WDAY = 3'h6;
  localparam logic [3:0] MAX_MON  = 4'hc;
  localparam logic [6:0] MAX_YEAR = 7'h63;

  // running time, binary, 24-hour
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] mon;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [6:0] hund;
  } bcdrtc_time_t;

  localparam bcdrtc_time_t TIME_RST = '{year: 7'h00, mon: 4'h1, day: 5'h01, wday: 3'h0,
                                        hour: 5'h00, min: 6'h00, sec: 6'h00, hund: 7'h00};

  function automatic logic bcd_ok(input logic [7:0] b);
    return (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
  endfunction

  function automatic logic [6:0] bcd2bin(input logic [7:0] b);
    return 7'({3'h0, b[7:4]} * 7'h0a + {3'h0, b[3:0]});
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'h0a;
    return {t[3:0], 4'(v - t * 7'h0a)};
  endfunction

  // year 00 is taken as leap, as in the 2000-2099 span
  function automatic logic [4:0] month_days(input logic [3:0] mon, input logic [6:0] year);
    unique case (mon)
      4'h2:                      month_days = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb:    month_days = 5'h1e;
      default:                   month_days = 5'h1f;
    endcase
  endfunction

endpackage

// file: hdl/bcdrtc_adv.sv
// bcdrtc_adv: next running time after one 10 ms step, pure combinational carry chain.
// assumes a valid binary time at its input.
`timescale 1ns/1ps
module bcdrtc_adv (
  // time in and out
  input  wire bcdrtc_pkg::bcdrtc_time_t cur_i,
  output bcdrtc_pkg::bcdrtc_time_t      nxt_o
);
  logic c_sec, c_min, c_hour, c_day, c_mon, c_year;

  always_comb begin
    nxt_o  = cur_i;
    c_sec  = (cur_i.hund == bcdrtc_pkg::MAX_HUND);
    c_min  = c_sec && (cur_i.sec == bcdrtc_pkg::MAX_MS);
    c_hour = c_min && (cur_i.min == bcdrtc_pkg::MAX_MS);
    c_day  = c_hour && (cur_i.hour == bcdrtc_pkg::MAX_HOUR);
    c_mon  = c_day && (cur_i.day == bcdrtc_pkg::month_days(cur_i.mon, cur_i.year));
    c_year = c_mon && (cur_i.mon == bcdrtc_pkg::MAX_MON);
    nxt_o.hund = c_sec ? 7'h00 : 7'(cur_i.hund + 7'h01);
    if (c_sec) begin
      nxt_o.sec = c_min ? 6'h00 : 6'(cur_i.sec + 6'h01);
    end
    if (c_min) begin
      nxt_o.min = c_hour ? 6'h00 : 6'(cur_i.min + 6'h01);
    end
    if (c_hour) begin
      nxt_o.hour = c_day ? 5'h00 : 5'(cur_i.hour + 5'h01);
    end
    if (c_day) begin
      nxt_o.wday = (cur_i.wday == bcdrtc_pkg::MAX_WDAY) ? 3'h0 : 3'(cur_i.wday + 3'h1);
      nxt_o.day  = c_mon ? 5'h01 : 5'(cur_i.day + 5'h01);
    end
    if (c_mon) begin
      nxt_o.mon = c_year ? 4'h1 : 4'(cur_i.mon + 4'h1);
    end
    if (c_year) begin
      nxt_o.year = (cur_i.year == bcdrtc_pkg::MAX_YEAR) ? 7'h00 : 7'(cur_i.year + 7'h01);
    end
  end
endmodule // bcdrtc_adv

// file: hdl/bcdrtc_chk.sv
// bcdrtc_chk: checks the four set words and converts them to a binary 24-hour time.
// assumes the words are stable while the result is used.
`timescale 1ns/1ps
module bcdrtc_chk (
  // set words
  input  wire logic [15:0]              w0_i,
  input  wire logic [15:0]              w1_i,
  input  wire logic [15:0]              w2_i,
  input  wire logic [15:0]              w3_i,
  // result
  output bcdrtc_pkg::bcdrtc_time_t      tm_o,
  output logic                          fmt24_o,
  output logic [7:0]                    err_o
);
  logic [6:0] hb;
  logic       pm;
  logic       hour_ok;
  // full-width binary values, so an out-of-range byte is not hidden by truncation
  logic [6:0] mon_b;
  logic [6:0] day_b;
  logic [6:0] min_b;
  logic [6:0] sec_b;

  always_comb begin
    mon_b       = bcdrtc_pkg::bcd2bin(w3_i[7:0]);
    day_b       = bcdrtc_pkg::bcd2bin(w2_i[15:8]);
    min_b       = bcdrtc_pkg::bcd2bin(w1_i[7:0]);
    sec_b       = bcdrtc_pkg::bcd2bin(w0_i[15:8]);
    fmt24_o     = w1_i[bcdrtc_pkg::FMT24_BIT];
    pm          = w1_i[bcdrtc_pkg::PM_BIT];
    hb          = bcdrtc_pkg::bcd2bin({2'h0, w1_i[13:8]});
    tm_o.year   = bcdrtc_pkg::bcd2bin(w3_i[15:8]);
    tm_o.mon    = 4'(mon_b);
    tm_o.day    = 5'(day_b);
    tm_o.wday   = w2_i[6:4];
    tm_o.min    = 6'(min_b);
    tm_o.sec    = 6'(sec_b);
    tm_o.hund   = 7'h00;
    // 12 am is midnight, 12 pm is noon
    if (fmt24_o) begin
      tm_o.hour = 5'(hb);
      hour_ok   = !pm && (hb <= 7'(bcdrtc_pkg::MAX_HOUR));
    end else begin
      tm_o.hour = 5'((hb == 7'h0c) ? (pm ? 7'h0c : 7'h00) : (pm ? hb + 7'h0c : hb));
      hour_ok   = (hb >= 7'h01) && (hb <= 7'h0c);
    end
    // first failing field in documented priority order
    if (!bcdrtc_pkg::bcd_ok(w3_i[15:8])) begin
      err_o = bcdrtc_pkg::ERR_YEAR;
    end else if (!bcdrtc_pkg::bcd_ok(w3_i[7:0]) || mon_b == 7'h00
                 || mon_b > {3'h0, bcdrtc_pkg::MAX_MON}) begin
      err_o = bcdrtc_pkg::ERR_MONTH;
    end else if (!bcdrtc_pkg::bcd_ok(w2_i[15:8]) || day_b == 7'h00
                 || day_b > {2'h0, bcdrtc_pkg::month_days(tm_o.mon, tm_o.year)}) begin
      err_o = bcdrtc_pkg::ERR_DAY;
    end else if (w2_i[7] || tm_o.wday > bcdrtc_pkg::MAX_WDAY) begin
      err_o = bcdrtc_pkg::ERR_WDAY;
    end else if (!bcdrtc_pkg::bcd_ok({2'h0, w1_i[13:8]}) || !hour_ok) begin
      err_o = bcdrtc_pkg::ERR_HOUR;
    end else if (!bcdrtc_pkg::bcd_ok(w1_i[7:0]) || min_b > {1'h0, bcdrtc_pkg::MAX_MS}) begin
      err_o = bcdrtc_pkg::ERR_MIN;
    end else if (!bcdrtc_pkg::bcd_ok(w0_i[15:8]) || sec_b > {1'h0, bcdrtc_pkg::MAX_MS}) begin
      err_o = bcdrtc_pkg::ERR_SEC;
    end else if (w0_i[7:0] != 8'h00) begin
      err_o = bcdrtc_pkg::ERR_HUND;
    end else if (w2_i[3:0] != 4'h0) begin
      err_o = bcdrtc_pkg::ERR_LOWB;
    end else begin
      err_o = bcdrtc_pkg::ERR_NONE;
    end
  end
endmodule // bcdrtc_chk

// file: sim/bcdrtc_assertions.sv
// bcdrtc_assertions: port-level checks of the bcd clock slave, bound into bcdrtc_top.
// assumes single-word ahb transfers, one clock domain; sys_rst_i disables every check.
`timescale 1ns/1ps
module bcdrtc_assertions #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // clock and resets
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        por_i,
  // ahb-lite slave
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic        hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // interrupt
  input wire logic        irq_o
);
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [2:0] mask_sh;
  wire        acc = hsel_i && htrans_i[1] && hready_i;
  wire        rd  = acc && !hwrite_i;

  // shadow of the mask so irq can be tied to what software wrote
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      mask_sh <= 3'h0;
    end else if (hready_i) begin
      wr_pend <= acc && hwrite_i;
      wr_addr <= (haddr_i[31:8] != 24'h0) ? 8'hff : haddr_i[7:0];
      if (wr_pend && wr_addr == 8'h1c) mask_sh <= hwdata_i[2:0];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_okay; hresp_o == 1'b0; endproperty
  property p_ready; !sys_rst_i |=> hreadyout_o; endproperty
  property p_cmd_zero; rd && haddr_i == 32'h10 |=> hrdata_o == 32'h0; endproperty
  property p_unmapped; rd && haddr_i[31:6] != 26'h0 |=> hrdata_o == 32'h0; endproperty
  property p_state; rd && haddr_i == 32'h14 |=> hrdata_o[31:16] == 16'h0 && hrdata_o[7:2] == 6'h0
    && hrdata_o[15:8] <= 8'h09; endproperty
  property p_field; rd && haddr_i[31:4] == 28'h0 |=> hrdata_o[31:16] == 16'h0; endproperty
  property p_flag; rd && haddr_i[31:5] == 27'h1 |=> hrdata_o[31:8] == 24'h0; endproperty
  property p_hold; !acc |=> $stable(hrdata_o); endproperty
  property p_irq_mask; $past(mask_sh) == 3'h0 && mask_sh == 3'h0 |-> !irq_o; endproperty

  a_okay: assert property (p_okay) else $error("response not okay");
  a_ready: assert property (p_ready) else $error("slave stalled");
  a_cmd_zero: assert property (p_cmd_zero) else $error("command reads nonzero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_state: assert property (p_state) else $error("state word out of range");
  a_field: assert property (p_field) else $error("field word wider than 16 bits");
  a_flag: assert property (p_flag) else $error("flag byte wider than 8 bits");
  a_hold: assert property (p_hold) else $error("read data moved without access");
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");

  c_state: cover property (rd && haddr_i == 32'h14);
  c_cmd: cover property (acc && hwrite_i && haddr_i == 32'h10);
  c_irq: cover property ($rose(irq_o));
endmodule // bcdrtc_assertions

// file: sim/bcdrtc_tb_top.sv
// bcdrtc_tb_top: self-checking bench of the bcd clock through its ahb-lite slave.
// assumes a shortened tick; reads are noted in a queue and checked by a monitor.
`timescale 1ns/1ps
module bcdrtc_tb_top;
  localparam int unsigned TICK = 4;
  localparam logic [63:0] BASE = 64'h4500_9330_1520_0806;
  localparam logic [63:0] NOHUND = 64'hff00_ffff_ffff_ffff;
  localparam logic [127:0] ROLL [5] = '{128'h5900_a359_3160_9912_0000_8000_0100_0001,
    128'h5900_a359_2830_0402_0000_8000_2940_0402, 128'h5900_a359_2830_0302_0000_8000_0140_0303,
    128'h5900_5159_3000_0704_0000_1200_0110_0705, 128'h5900_1159_1520_0806_0000_5200_1520_0806};
  localparam logic [71:0] BAD [11] = '{72'h0001_9330_1520_0806_08, 72'h4500_9330_1521_0806_09,
    72'h4500_9365_1520_0806_06,
    72'h4500_9330_3010_0302_03, 72'h4500_9330_2910_0302_03, 72'h4500_9330_1520_0813_02,
    72'h4500_a430_1520_0806_05, 72'h4500_d330_1520_0806_05, 72'h6000_9330_1520_0806_07,
    72'h4500_9330_1570_0806_04, 72'h4500_1330_1520_0806_05};
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        por_i     = 1'b1;
  logic        hsel_i    = 1'b0;
  logic        hwrite_i  = 1'b0;
  logic [31:0] haddr_i   = 32'h0;
  logic [1:0]  htrans_i  = 2'h0;
  logic [2:0]  hsize_i   = 3'h2;
  logic [31:0] hwdata_i  = 32'h0;
  logic        rd_dp     = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o, hresp_o, irq_o;
  wire         hready_i = hreadyout_o;
  logic [31:0] exp_q[$], msk_q[$];
  int          n_errors = 0, n_compared = 0;
  integer      seed = 32'h41ddb075;

  initial forever #50 clk_i = ~clk_i;

  bcdrtc_top #(.TICK_CYCLES(TICK)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .irq_o(irq_o));

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // always one idle cycle before the address phase, so commands settle before read-back
  task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wr ? d : 32'h0;
    do @(posedge clk_i); while (hready_i !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] mk);
    exp_q.push_back(x);
    msk_q.push_back(mk);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic set_time(input logic [63:0] f);
    for (int i = 0; i < 4; i++) xfer(32'(4 * i), 1'b1, {16'h0, f[63 - 16 * i -: 16]});
    xfer(32'h10, 1'b1, 32'h1);
  endtask

  task automatic get_time(input logic [63:0] f, input logic [63:0] mk);
    xfer(32'h10, 1'b1, 32'h2);
    for (int i = 0; i < 4; i++) rd(32'(4 * i), {16'h0, f[63 - 16 * i -: 16]}, {16'hffff, mk[63 - 16 * i -: 16]});
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // monitor: read data is taken at the edge that ends the data phase
  always @(posedge clk_i) begin
    if (rd_dp && hready_i === 1'b1) chk(hrdata_o, exp_q.pop_front(), msk_q.pop_front());
    if (hready_i === 1'b1) rd_dp <= hsel_i && htrans_i[1] && !hwrite_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end

  initial begin
    int h, mi, s, wd;
    logic [63:0] f;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    por_i     <= 1'b0;
    rd(32'h14, 32'h2, '1);
    xfer(32'h40, 1'b1, 32'hffff_ffff);
    rd(32'h40, 32'h0, '1);
    rd(32'h10, 32'h0, '1);
    $display("test map done");
    for (int i = 0; i < 3; i++) begin
      s  = $unsigned($random(seed)) % 60;
      h  = $unsigned($random(seed)) % 24;
      mi = $unsigned($random(seed)) % 60;
      wd = $unsigned($random(seed)) % 7;
      f  = {bcd(s), 8'h00, 8'h80 | bcd(h), bcd(mi), 8'h28, 1'b0, 3'(wd), 4'h0, 8'h12, 8'h02};
      set_time(f);
      get_time(f, NOHUND);
      rd(32'h24, {24'h0, 8'h80 | bcd(h)}, '1);
      rd(32'h34, {24'h0, bcd(mi)}, '1);
    end
    $display("test set and read done");
    foreach (ROLL[i]) begin
      set_time(ROLL[i][127:64]);
      repeat (440) @(posedge clk_i);
      get_time(ROLL[i][63:0], NOHUND);
    end
    $display("test carry done");
    set_time(BASE);
    rd(32'h14, 32'h3, '1);
    xfer(32'h1c, 1'b1, 32'h2);
    foreach (BAD[i]) begin
      set_time(BAD[i][71:8]);
      rd(32'h14, {16'h0, BAD[i][7:0], 8'h03}, '1);
    end
    chk({31'h0, irq_o}, 32'h1, 32'h1);
    xfer(32'h18, 1'b1, 32'h2);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0, 32'h1);
    xfer(32'h1c, 1'b1, 32'h0);
    set_time(BAD[0][71:8]);
    rd(32'h18, 32'h2, 32'h2);
    chk({31'h0, irq_o}, 32'h0, 32'h1);
    get_time({16'h0, BASE[47:0]}, 64'h0000_ffff_ffff_ffff);
    $display("test set errors done");
    // warm reset only: the running time must ride through it
    sys_rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    get_time({16'h0, BASE[47:0]}, 64'h0000_ffff_ffff_ffff);
    rd(32'h14, 32'h3, 32'h3);
    $display("test warm restart done");
    repeat (4) @(posedge clk_i);
    report_and_stop();
  end
endmodule // bcdrtc_tb_top

bind bcdrtc_top bcdrtc_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_assert (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .por_i(por_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hsize_i(hsize_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o));
